// *** verilog/limiter_coefficient_control.sv ***
// module: limiter setting decode, limiter gain control and coefficient staging and ram
`timescale 1ns/10ps

module limiter_coefficient_control #(
  parameter int unsigned MS_CYCLES = limcoef_pkg::MS_TICK_CYCLES
) (
  input wire logic mclk, // 10 MHz audio clock
  input wire logic resetn, // asynchronous reset, active low
  input wire logic [7:0] reg_addr, // register index from the control port
  input wire logic [7:0] reg_wdata, // register write byte
  input wire logic reg_wr, // one-cycle write strobe
  input wire logic reg_rd, // one-cycle read strobe
  output logic [7:0] reg_rdata, // read byte, valid the cycle after reg_rd
  input wire logic [1:0][7:0] peak_db, // largest mapped peak per limiter, signed dB
  input wire logic [1:0][7:0] rms_db, // rms filtered level per limiter, signed dB
  input wire logic [1:0][7:0] volume_db, // highest mapped volume per limiter, signed dB
  output logic compression_mode_select, // 1 compression, 0 anti-clip
  output logic [1:0][15:0] limiter_attack_rate, // 0.0001 dB/ms
  output logic [1:0][15:0] limiter_release_rate, // 0.0001 dB/ms
  output logic [1:0][9:0] limiter_attack_threshold, // signed dB, absolute
  output logic [1:0][9:0] limiter_release_threshold, // signed dB, absolute
  output logic [1:0] release_unbounded, // release only at silence
  output logic [1:0][23:0] gain_reduction, // 0.0001 dB units
  input wire logic [5:0] coef_rd_addr, // filter-side ram read address
  output logic [23:0] coef_rd_data // filter-side ram data, one cycle later
);

  typedef struct packed {
    logic comp_mode;
    logic [3:0][7:0] lim;
    logic [5:0] ram_addr;
    logic [limcoef_pkg::STAGE_BYTES-1:0][7:0] stage;
    logic [63:0][23:0] ram;
    logic [7:0] rdata;
    logic [23:0] coef_q;
    logic [15:0] tick_cnt;
    logic [1:0][15:0] atk_rate;
    logic [1:0][15:0] rel_rate;
    logic [1:0][9:0] atk_thr;
    logic [1:0][9:0] rel_thr;
    logic [1:0] rel_inf;
    logic [1:0][23:0] atten;
  } state_t;

  state_t st;
  state_t next_st;
  logic tick;
  logic [1:0] over;
  logic [1:0] rel_ok;
  logic signed [1:0][9:0] atk_abs;
  logic signed [1:0][9:0] rel_abs;
  logic [1:0] inf;

  function automatic logic is_lim(input logic [7:0] a);
    return a >= limcoef_pkg::LIM1_RATE_REG && a <= limcoef_pkg::LIM2_THR_REG;
  endfunction

  function automatic logic is_stage(input logic [7:0] a);
    return a >= limcoef_pkg::STAGE_FIRST_REG && a <= limcoef_pkg::STAGE_LAST_REG;
  endfunction

  // --------------------------------------------------------------
  // threshold decode and limiter decisions
  // --------------------------------------------------------------
  // one-millisecond tick paces both slopes
  assign tick = st.tick_cnt == 16'(MS_CYCLES - 1);

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      logic [3:0] atc;
      logic [3:0] rtc;
      atc = st.lim[2*i+1][7:4];
      rtc = st.lim[2*i+1][3:0];
      inf[i] = rtc == 4'h0;
      if (st.comp_mode)
      begin
        atk_abs[i] = limcoef_pkg::sext8(volume_db[i])
          + limcoef_pkg::sext8(limcoef_pkg::DRC_ATTACK_THR[atc]);
        rel_abs[i] = atk_abs[i] + limcoef_pkg::sext8(limcoef_pkg::DRC_RELEASE_THR[rtc]);
      end
      else
      begin
        atk_abs[i] = limcoef_pkg::sext8(limcoef_pkg::AC_ATTACK_THR[atc]);
        rel_abs[i] = limcoef_pkg::sext8(limcoef_pkg::AC_RELEASE_THR[rtc]);
      end
      // an element of a packed array is unsigned, so compare as signed on purpose
      over[i] = limcoef_pkg::sext8(peak_db[i]) > $signed(atk_abs[i]);
      // with an unbounded threshold only silence lets the gain recover
      rel_ok[i] = inf[i] ? (rms_db[i] == limcoef_pkg::SILENCE_DB)
        : (limcoef_pkg::sext8(rms_db[i]) < $signed(rel_abs[i]));
    end
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb
  begin
    logic [5:0] a;
    logic [24:0] sum;
    logic [7:0] rd;
    a = '0;
    sum = '0;
    rd = 8'h00;
    next_st = st;
    next_st.tick_cnt = tick ? 16'h0000 : st.tick_cnt + 16'h0001;
    next_st.coef_q = st.ram[coef_rd_addr];
    // register writes; staging bytes only load holding registers
    if (reg_wr)
    begin
      if (reg_addr == limcoef_pkg::CFG_REG)
        next_st.comp_mode = reg_wdata[limcoef_pkg::COMP_MODE_BIT];
      else if (is_lim(reg_addr))
        next_st.lim[2'(reg_addr - limcoef_pkg::LIM1_RATE_REG)] = reg_wdata;
      else if (reg_addr == limcoef_pkg::COEF_ADDR_REG)
        next_st.ram_addr = reg_wdata[5:0];
      else if (is_stage(reg_addr))
        next_st.stage[4'(reg_addr - limcoef_pkg::STAGE_FIRST_REG)] = reg_wdata;
      else if (reg_addr == limcoef_pkg::COEF_CTRL_REG)
      begin
        // set write moves all five staged words to base plus offset
        for (int k = 0; k < limcoef_pkg::COEF_SET_SIZE; k++)
        begin
          a = st.ram_addr + 6'(k);
          if (reg_wdata[limcoef_pkg::CTRL_WA_BIT] || (k == 0 && reg_wdata[limcoef_pkg::CTRL_W1_BIT]))
            next_st.ram[a] = {st.stage[3*k], st.stage[3*k+1], st.stage[3*k+2]};
          if (reg_wdata[limcoef_pkg::CTRL_RA_BIT] || (k == 0 && reg_wdata[limcoef_pkg::CTRL_R1_BIT]))
            {next_st.stage[3*k], next_st.stage[3*k+1], next_st.stage[3*k+2]} = st.ram[a];
        end
      end
    end
    // register reads; trigger bits clear themselves and read zero
    if (reg_addr == limcoef_pkg::CFG_REG)
      rd = {7'h00, st.comp_mode};
    else if (is_lim(reg_addr))
      rd = st.lim[2'(reg_addr - limcoef_pkg::LIM1_RATE_REG)];
    else if (reg_addr == limcoef_pkg::COEF_ADDR_REG)
      rd = {2'b00, st.ram_addr};
    else if (is_stage(reg_addr))
      rd = st.stage[4'(reg_addr - limcoef_pkg::STAGE_FIRST_REG)];
    if (reg_rd)
      next_st.rdata = rd;
    // decoded settings and gain slopes per limiter
    for (int i = 0; i < 2; i++)
    begin
      next_st.atk_rate[i] = limcoef_pkg::ATTACK_RATE[st.lim[2*i][7:4]];
      next_st.rel_rate[i] = limcoef_pkg::RELEASE_RATE[st.lim[2*i][3:0]];
      next_st.atk_thr[i] = atk_abs[i];
      next_st.rel_thr[i] = rel_abs[i];
      next_st.rel_inf[i] = inf[i];
      if (tick && over[i])
      begin
        sum = {1'b0, st.atten[i]} + {9'h000, limcoef_pkg::ATTACK_RATE[st.lim[2*i][7:4]]};
        next_st.atten[i] = sum[24] ? 24'hffffff : sum[23:0];
      end
      else if (tick && rel_ok[i] && st.atten[i] != 24'h000000)
      begin
        // recovery stops at the set gain
        if (st.atten[i] > {8'h00, limcoef_pkg::RELEASE_RATE[st.lim[2*i][3:0]]})
          next_st.atten[i] = st.atten[i] - {8'h00, limcoef_pkg::RELEASE_RATE[st.lim[2*i][3:0]]};
        else
          next_st.atten[i] = 24'h000000;
      end
    end
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= '0;
      st.comp_mode <= limcoef_pkg::CFG_RESET[limcoef_pkg::COMP_MODE_BIT];
      st.lim <= {limcoef_pkg::THR_RESET, limcoef_pkg::RATE_RESET,
                 limcoef_pkg::THR_RESET, limcoef_pkg::RATE_RESET};
      st.ram_addr <= limcoef_pkg::COEF_RESET[5:0];
      st.stage <= {limcoef_pkg::STAGE_BYTES{limcoef_pkg::COEF_RESET}};
    end
    else
      st <= next_st;
  end

  // outputs straight from the state register
  assign reg_rdata = st.rdata;
  assign compression_mode_select = st.comp_mode;
  assign limiter_attack_rate = st.atk_rate;
  assign limiter_release_rate = st.rel_rate;
  assign limiter_attack_threshold = st.atk_thr;
  assign limiter_release_threshold = st.rel_thr;
  assign release_unbounded = st.rel_inf;
  assign gain_reduction = st.atten;
  assign coef_rd_data = st.coef_q;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence ctrl_wr;
    reg_wr && reg_addr == limcoef_pkg::COEF_CTRL_REG;
  endsequence
  sequence set_req;
    ctrl_wr and reg_wdata[limcoef_pkg::CTRL_WA_BIT];
  endsequence
  sequence single_req;
    ctrl_wr and (reg_wdata[limcoef_pkg::CTRL_W1_BIT] && !reg_wdata[limcoef_pkg::CTRL_WA_BIT]);
  endsequence

  stage_hold_a: assert property (reg_wr && reg_addr != limcoef_pkg::COEF_CTRL_REG
    |=> $stable(st.ram)) else $error("ram changed without a trigger");
  single_write_a: assert property (single_req |=> st.ram[$past(st.ram_addr)]
    == {$past(st.stage[0]), $past(st.stage[1]), $past(st.stage[2])})
    else $error("single coefficient not written");
  set_write_a: assert property (set_req |=> st.ram[6'($past(st.ram_addr) + 6'h4)]
    == {$past(st.stage[12]), $past(st.stage[13]), $past(st.stage[14])})
    else $error("fifth coefficient of set not written");
  addr_mask_a: assert property (reg_wr && reg_addr == limcoef_pkg::COEF_ADDR_REG
    ##1 !reg_wr ##1 !reg_wr && reg_rd && reg_addr == limcoef_pkg::COEF_ADDR_REG
    |=> reg_rdata == {2'b00, $past(reg_wdata[5:0], 3)})
    else $error("address register readback wrong");
  mode_sel_a: assert property (reg_wr && reg_addr == limcoef_pkg::CFG_REG
    |=> compression_mode_select == $past(reg_wdata[0]))
    else $error("mode bit not taken");
  attack_fast_a: assert property (reg_wr && reg_addr == limcoef_pkg::LIM1_RATE_REG
    && reg_wdata[7:4] == 4'h0 ##1 !reg_wr |=> limiter_attack_rate[0] == 16'h7b60)
    else $error("fastest attack slope wrong");
  release_slow_a: assert property (reg_wr && reg_addr == limcoef_pkg::LIM1_RATE_REG
    && reg_wdata[3:0] == 4'hf ##1 !reg_wr |=> limiter_release_rate[0] == 16'h0068)
    else $error("slowest release slope wrong");
  ac_zero_a: assert property (!$past(st.comp_mode) && $past(st.lim[1][7:4]) == 4'h6
    |-> limiter_attack_threshold[0] == 10'h000)
    else $error("anti-clip attack threshold wrong");
  drc_low_a: assert property (st.comp_mode && st.lim[1][7:4] == 4'h0
    |-> atk_abs[0] == limcoef_pkg::sext8(volume_db[0]) - 10'sd31)
    else $error("compression attack threshold wrong");
  rel_inf_a: assert property (st.lim[3][3:0] == 4'h0 |=> release_unbounded[1])
    else $error("release code zero not unbounded");
  gain_up_a: assert property (st.atten[0] > $past(st.atten[0]) |-> $past(tick && over[0]))
    else $error("gain reduced without a peak");
  gain_down_a: assert property (st.atten[0] < $past(st.atten[0]) |-> $past(tick && rel_ok[0]))
    else $error("gain raised without release condition");

endmodule

// *** verilog/limcoef_pkg.sv ***
// package: register map, reset values and decode tables of the limiter and coefficient block
package limcoef_pkg;
  // register offsets on the byte register port
  localparam logic [7:0] CFG_REG = 8'h05;
  localparam logic [7:0] LIM1_RATE_REG = 8'h12;
  localparam logic [7:0] LIM2_THR_REG = 8'h15;
  localparam logic [7:0] COEF_ADDR_REG = 8'h16;
  localparam logic [7:0] STAGE_FIRST_REG = 8'h17;
  localparam logic [7:0] STAGE_LAST_REG = 8'h25;
  localparam logic [7:0] COEF_CTRL_REG = 8'h26;
  // field positions
  localparam int COMP_MODE_BIT = 0;
  localparam int CTRL_W1_BIT = 0;
  localparam int CTRL_WA_BIT = 1;
  localparam int CTRL_R1_BIT = 2;
  localparam int CTRL_RA_BIT = 3;
  // values after reset
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h6a;
  localparam logic [7:0] THR_RESET = 8'h69;
  localparam logic [7:0] COEF_RESET = 8'h00;
  // sizes
  localparam int COEF_SET_SIZE = 5;
  localparam int STAGE_BYTES = 15;
  // millisecond tick for the gain slopes
  localparam int unsigned MS_TIME_NS = 1000000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MS_TICK_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;
  // level code meaning silence, used for an unbounded release threshold
  localparam logic [7:0] SILENCE_DB = 8'h80;
  // slopes in units of 0.0001 dB/ms, listed from code 1111 down to code 0000
  localparam logic [15:0][15:0] ATTACK_RATE = {
    16'h01c3, 16'h01f5, 16'h0234, 16'h0285, 16'h02f0, 16'h0386, 16'h0463, 16'h05e0,
    16'h08d0, 16'h11a0, 16'h2340, 16'h34e0, 16'h4680, 16'h5820, 16'h69c0, 16'h7b60};
  localparam logic [15:0][15:0] RELEASE_RATE = {
    16'h0068, 16'h006e, 16'h0075, 16'h0086, 16'h0089, 16'h0093, 16'h00ac, 16'h00c6,
    16'h00d0, 16'h0108, 16'h012b, 16'h0168, 16'h01f3, 16'h02e8, 16'h055a, 16'h13fc};
  // thresholds in signed dB, listed from code 1111 down to code 0000
  localparam logic [15:0][7:0] AC_ATTACK_THR = {
    8'h0a, 8'h09, 8'h08, 8'h07, 8'h06, 8'h05, 8'h04, 8'h03,
    8'h02, 8'h00, 8'hfe, 8'hfc, 8'hfa, 8'hf8, 8'hf6, 8'hf4};
  localparam logic [15:0][7:0] AC_RELEASE_THR = {
    8'h00, 8'hff, 8'hfe, 8'hfd, 8'hfc, 8'hfb, 8'hfa, 8'hf9,
    8'hf8, 8'hf6, 8'hf4, 8'hf2, 8'hf0, 8'hec, 8'he3, 8'h80};
  localparam logic [15:0][7:0] DRC_ATTACK_THR = {
    8'hfc, 8'hf9, 8'hf6, 8'hf4, 8'hf3, 8'hf2, 8'hf1, 8'hf0,
    8'hef, 8'hed, 8'heb, 8'he9, 8'he7, 8'he5, 8'he3, 8'he1};
  localparam logic [15:0][7:0] DRC_RELEASE_THR = {
    8'hfa, 8'hf7, 8'hf4, 8'hf1, 8'hee, 8'hec, 8'hea, 8'he8,
    8'he6, 8'he4, 8'he2, 8'he1, 8'hdf, 8'hdc, 8'hda, 8'h80};

  // sign extension of a dB code to the threshold arithmetic width
  function automatic logic signed [9:0] sext8(input logic [7:0] v);
    return {{2{v[7]}}, v};
  endfunction
endpackage

// *** tb/limcoef_host.sv ***
// host model: byte register master that stands behind the control port
`timescale 1ns/10ps
module limcoef_host (
  input wire logic mclk, // audio clock
  output logic [7:0] reg_addr, // register index
  output logic [7:0] reg_wdata, // write byte
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata // read byte
);
  // idle bus at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one-cycle write; released fields are scrambled so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  end
  endtask
  // one-cycle read; the byte is taken once the answering edge has passed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
  begin
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  end
  endtask
endmodule

// *** tb/tb.sv ***
// testbench: register map, setting decode, coefficient loading and gain control
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module tb;
  // ----------------------------------------------------------------
  // clock, reset, design and host
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, compression_mode_select;
  logic [1:0][7:0] peak_db, rms_db, volume_db;
  logic [1:0][15:0] limiter_attack_rate, limiter_release_rate;
  logic [1:0][9:0] limiter_attack_threshold, limiter_release_threshold;
  logic [1:0] release_unbounded;
  logic [1:0][23:0] gain_reduction;
  logic [5:0] coef_rd_addr;
  logic [23:0] coef_rd_data;
  int err_count = 0;
  int compares = 0;
  logic [15:0] atk[16] = '{16'h7b60, 16'h69c0, 16'h5820, 16'h4680, 16'h34e0, 16'h2340,
    16'h11a0, 16'h08d0, 16'h05e0, 16'h0463, 16'h0386, 16'h02f0, 16'h0285, 16'h0234,
    16'h01f5, 16'h01c3};
  logic [15:0] rel[16] = '{16'h13fc, 16'h055a, 16'h02e8, 16'h01f3, 16'h0168, 16'h012b,
    16'h0108, 16'h00d0, 16'h00c6, 16'h00ac, 16'h0093, 16'h0089, 16'h0086, 16'h0075,
    16'h006e, 16'h0068};
  always #50 mclk = ~mclk;
  limcoef_host i_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  limiter_coefficient_control #(.MS_CYCLES(8)) i_dut (.mclk(mclk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .peak_db(peak_db), .rms_db(rms_db), .volume_db(volume_db),
    .compression_mode_select(compression_mode_select),
    .limiter_attack_rate(limiter_attack_rate), .limiter_release_rate(limiter_release_rate),
    .limiter_attack_threshold(limiter_attack_threshold),
    .limiter_release_threshold(limiter_release_threshold),
    .release_unbounded(release_unbounded), .gain_reduction(gain_reduction),
    .coef_rd_addr(coef_rd_addr), .coef_rd_data(coef_rd_data));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
  begin
    i_host.rd(a, d);
    `CHK(d, e)
  end
  endtask
  task automatic ramchk(input logic [5:0] a, input logic [23:0] e);
  begin
    @(negedge mclk);
    coef_rd_addr = a;
    @(negedge mclk);
    `CHK(coef_rd_data, e)
  end
  endtask
  task automatic end_of_test();
  begin
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset contents, unmapped index and the unused address bits
  task automatic test_regs();
  begin
    rdchk(8'h05, 8'h00);
    for (int a = 8'h16; a <= 8'h26; a++) rdchk(a[7:0], 8'h00);
    for (int a = 8'h12; a <= 8'h15; a++) rdchk(a[7:0], a[0] ? 8'h69 : 8'h6a);
    `CHK(limiter_attack_rate[0], 16'h11a0)
    `CHK(limiter_release_rate[1], 16'h0093)
    `CHK(limiter_attack_threshold[0], 10'h000)
    `CHK(limiter_release_threshold[1], 10'h3fa)
    i_host.wr(8'h16, 8'hff);
    rdchk(8'h16, 8'h3f);
    i_host.wr(8'h30, 8'h55);
    rdchk(8'h30, 8'h00);
    i_host.wr(8'h16, 8'h00);
    $display("test regs done");
  end
  endtask
  // every rate code on both limiters, opposite codes on each
  task automatic test_rates();
    logic [3:0] c;
  begin
    for (int i = 0; i < 16; i++)
    begin
      c = i[3:0];
      i_host.wr(8'h12, {c, c});
      i_host.wr(8'h14, ~{c, c});
      repeat (3) @(negedge mclk);
      `CHK(limiter_attack_rate[0], atk[i])
      `CHK(limiter_release_rate[0], rel[i])
      `CHK(limiter_attack_rate[1], atk[15 - i])
      `CHK(limiter_release_rate[1], rel[15 - i])
    end
    i_host.wr(8'h12, 8'h6a);
    i_host.wr(8'h14, 8'h6a);
    $display("test rates done");
  end
  endtask
  // threshold end points in clipping and in compression mode
  task automatic test_thresholds();
    logic [7:0] cd[3] = '{8'h01, 8'h6f, 8'hf0};
    logic [9:0] at[3] = '{10'h3f4, 10'h000, 10'h00a};
    logic [9:0] rt[3] = '{10'h3e3, 10'h000, 10'h000};
    logic [7:0] dc[2] = '{8'h01, 8'hff};
    logic [9:0] dat[2] = '{10'h3d7, 10'h3f2};
    logic [9:0] drt[2] = '{10'h3b1, 10'h3ec};
  begin
    for (int k = 0; k < 3; k++)
    begin
      i_host.wr(8'h13, cd[k]);
      repeat (3) @(negedge mclk);
      `CHK(limiter_attack_threshold[0], at[k])
      if (k < 2) `CHK(limiter_release_threshold[0], rt[k])
      `CHK(release_unbounded[0], k == 2)
    end
    i_host.wr(8'h15, 8'h60);
    repeat (3) @(negedge mclk);
    `CHK(release_unbounded[1], 1'b1)
    `CHK(limiter_release_threshold[1], 10'h380)
    i_host.wr(8'h15, 8'h69);
    repeat (3) @(negedge mclk);
    `CHK(release_unbounded[1], 1'b0)
    volume_db[0] = 8'hf6;
    i_host.wr(8'h05, 8'hff);
    rdchk(8'h05, 8'h01);
    for (int k = 0; k < 2; k++)
    begin
      i_host.wr(8'h13, dc[k]);
      repeat (3) @(negedge mclk);
      `CHK(compression_mode_select, 1'b1)
      `CHK(limiter_attack_threshold[0], dat[k])
      `CHK(limiter_release_threshold[0], drt[k])
    end
    i_host.wr(8'h05, 8'h00);
    i_host.wr(8'h13, 8'h69);
    volume_db[0] = 8'h00;
    repeat (3) @(negedge mclk);
    `CHK(compression_mode_select, 1'b0)
    $display("test thresholds done");
  end
  endtask
  // staged set write, ram untouched until triggered, then a single write
  task automatic test_coef();
    logic [7:0] b;
  begin
    i_host.wr(8'h16, 8'h05);
    for (int i = 0; i < 15; i++) i_host.wr(8'h17 + i[7:0], 8'ha0 + i[7:0]);
    for (int k = 0; k < 5; k++) ramchk(6'h05 + k[5:0], 24'h000000);
    rdchk(8'h17, 8'ha0);
    i_host.wr(8'h26, 8'h02);
    rdchk(8'h26, 8'h00);
    for (int k = 0; k < 5; k++)
    begin
      b = 8'ha0 + 8'(3 * k);
      ramchk(6'h05 + k[5:0], {b, b + 8'h01, b + 8'h02});
    end
    i_host.wr(8'h16, 8'h3f);
    i_host.wr(8'h17, 8'h11);
    i_host.wr(8'h18, 8'h22);
    i_host.wr(8'h19, 8'h33);
    ramchk(6'h3f, 24'h000000);
    i_host.wr(8'h26, 8'h01);
    ramchk(6'h3f, 24'h112233);
    ramchk(6'h0a, 24'h000000);
    // single and set read back into the staging bytes, the set wrapping past 3fh
    i_host.wr(8'h16, 8'h05);
    i_host.wr(8'h26, 8'h04);
    rdchk(8'h17, 8'ha0);
    rdchk(8'h19, 8'ha2);
    rdchk(8'h1a, 8'ha3);
    i_host.wr(8'h16, 8'h3f);
    i_host.wr(8'h26, 8'h08);
    rdchk(8'h18, 8'h22);
    rdchk(8'h1a, 8'h00);
    $display("test coef done");
  end
  endtask
  // peak attack, hold while rms is loud, release to the set gain only
  task automatic test_limiter();
    logic [23:0] g;
  begin
    peak_db[0] = 8'h03;
    rms_db[0] = 8'h00;
    repeat (40) @(negedge mclk);
    g = gain_reduction[0];
    `CHK((g % 24'h0011a0 == 24'h0) && g >= 24'h0034e0 && g <= 24'h005820, 1'b1)
    peak_db[0] = 8'h80;
    repeat (8) @(negedge mclk);
    g = gain_reduction[0];
    repeat (24) @(negedge mclk);
    `CHK(gain_reduction[0], g)
    rms_db[0] = 8'hd8;
    repeat (2000) @(negedge mclk);
    `CHK(gain_reduction[0], 24'h000000)
    `CHK(gain_reduction[1], 24'h000000)
    $display("test limiter done");
  end
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    peak_db = {8'h80, 8'h80};
    rms_db = {8'h80, 8'h80};
    volume_db = {8'h00, 8'h00};
    coef_rd_addr = 6'h00;
    repeat (16) @(negedge mclk);
    resetn = 1'b1;
    test_regs();
    test_rates();
    test_thresholds();
    test_coef();
    test_limiter();
    end_of_test();
  end
  initial
  begin
    #2000000;
    err_count++;
    end_of_test();
  end
endmodule
